// *** cbp_pkg.sv ***
// package for the cpu bus pin protocol block: constants, states and carriers
package cbp_pkg;
    localparam int unsigned data_width = 16;
    localparam int unsigned seg_width = 7;
    localparam int unsigned status_width = 4;
    localparam int unsigned clock_rate_mhz = 10;
    localparam int unsigned reset_settle_clocks = 3;
    localparam int unsigned reset_float_clocks = 5;
    localparam int unsigned irq_sample_period = 3;
    localparam logic [15:0] flags_addr = 16'h0002;
    localparam logic [15:0] pcseg_addr = 16'h0004;
    localparam logic [15:0] pcoff_addr = 16'h0006;
    localparam logic [3:0] status_idle = 4'h0;
    localparam logic [3:0] status_reset = 4'hF;
    localparam logic [3:0] status_mem_read = 4'h8;
    localparam logic [3:0] status_mem_write = 4'h9;
    localparam logic [3:0] status_io = 4'h2;
    localparam logic [3:0] status_int_ack = 4'h5;
    localparam logic [3:0] status_fetch = 4'hC;

    typedef enum logic [7:0] {
        cbp_st_reset = 8'h01,
        cbp_st_boot = 8'h02,
        cbp_st_idle = 8'h04,
        cbp_st_t1 = 8'h08,
        cbp_st_t2 = 8'h10,
        cbp_st_t3 = 8'h20,
        cbp_st_granted = 8'h40,
        cbp_st_wait = 8'h80
    } cbp_state_type;

    typedef enum logic [2:0] {
        cbp_irq_none = 3'h0,
        cbp_irq_nmi = 3'h1,
        cbp_irq_vect = 3'h2,
        cbp_irq_plain = 3'h3,
        cbp_irq_trap = 3'h4
    } cbp_irq_type;

    typedef struct packed {
        logic valid;
        logic is_mem;
        logic is_read;
        logic is_byte;
        logic [15:0] addr;
        logic [6:0] seg;
        logic [15:0] wdata;
    } cbp_req_type;

    typedef struct packed {
        logic done;
        logic [15:0] rdata;
    } cbp_resp_type;
endpackage

// *** cbp_irq_sampler.sv ***
// interrupt and trap sampler: edge detect, two-sample qualify, priority pick
`timescale 1ns/10ps
`default_nettype none
module cbp_irq_sampler (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sample_now,
    input wire logic nmi_n,
    input wire logic vectored_irq_n,
    input wire logic plain_irq_n,
    input wire logic translation_trap_n,
    input wire logic taken,
    output cbp_pkg::cbp_irq_type irq_kind
);
    logic nmi_prev_reg;
    logic nmi_latch_reg;
    logic [3:0] first_reg;
    logic [3:0] now;
    cbp_pkg::cbp_irq_type kind_reg;

    assign now = {~translation_trap_n, ~plain_irq_n, ~vectored_irq_n, nmi_latch_reg};
    assign irq_kind = kind_reg;

    // nmi is caught on its falling edge only; a held low level does not retrigger
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nmi_prev_reg <= 1'b1;
            nmi_latch_reg <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi_n;
            if (nmi_prev_reg && !nmi_n)
                nmi_latch_reg <= 1'b1;
            else if (taken && kind_reg == cbp_pkg::cbp_irq_nmi)
                nmi_latch_reg <= 1'b0;
        end
    end

    // a source must be seen on two consecutive samples before it is reported
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            first_reg <= 4'h0;
            kind_reg <= cbp_pkg::cbp_irq_none;
        end else if (taken) begin
            kind_reg <= cbp_pkg::cbp_irq_none;
        end else if (sample_now) begin
            first_reg <= now;
            if (first_reg[0] && now[0])
                kind_reg <= cbp_pkg::cbp_irq_nmi;
            else if (first_reg[3] && now[3])
                kind_reg <= cbp_pkg::cbp_irq_trap;
            else if (first_reg[1] && now[1])
                kind_reg <= cbp_pkg::cbp_irq_vect;
            else if (first_reg[2] && now[2])
                kind_reg <= cbp_pkg::cbp_irq_plain;
        end
    end
endmodule // cbp_irq_sampler
`default_nettype wire

// *** cbp_bus_unit.sv ***
// bus interface unit: drives the multiplexed bus, strobes, qualifiers and arbitration
`timescale 1ns/10ps
`default_nettype none
module cbp_bus_unit #(
    parameter int unsigned data_w = cbp_pkg::data_width,
    parameter int unsigned seg_w = cbp_pkg::seg_width
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [data_w-1:0] mux_bus_in,
    output logic [data_w-1:0] mux_bus_out,
    output logic mux_bus_oe,
    output logic addr_strobe_n,
    output logic data_strobe_n,
    output logic mem_cycle_n,
    output logic read_not_write,
    output logic byte_select,
    output logic normal_mode,
    output logic ctrl_oe,
    output logic [seg_w-1:0] segment_number_out,
    output logic [3:0] cpu_phase_code,
    input wire logic bus_claim_n,
    output logic bus_grant_n,
    input wire logic chain_in_n,
    output logic chain_out_n,
    input wire logic nmi_n,
    input wire logic vectored_irq_n,
    input wire logic plain_irq_n,
    input wire logic translation_trap_n,
    input wire logic not_ready_n,
    input wire logic step_hold_n,
    input wire cbp_pkg::cbp_req_type core_req,
    input wire logic core_normal_mode,
    input wire logic core_chain_claim,
    output cbp_pkg::cbp_resp_type core_resp,
    output cbp_pkg::cbp_irq_type core_irq,
    output logic core_booted,
    output logic core_step_stall,
    output logic core_chain_owned
);
    cbp_pkg::cbp_state_type state_reg;
    cbp_pkg::cbp_req_type cur_reg;
    logic [2:0] rst_cnt_reg;
    logic [1:0] boot_idx_reg;
    logic booted_reg;
    logic [1:0] phase_cnt_reg;
    logic wait_fall_reg;
    logic step_fall_reg;
    logic irq_taken;
    logic [15:0] boot_addr;

    // boot fetch address from the word index, shared decode
    function automatic logic [15:0] boot_loc(input logic [1:0] idx);
        case (idx)
            2'h0: boot_loc = cbp_pkg::flags_addr;
            2'h1: boot_loc = cbp_pkg::pcseg_addr;
            default: boot_loc = cbp_pkg::pcoff_addr;
        endcase
    endfunction

    assign boot_addr = boot_loc(boot_idx_reg);
    assign irq_taken = (state_reg == cbp_pkg::cbp_st_t3) && (core_irq != cbp_pkg::cbp_irq_none)
                       && cur_reg.is_mem && cur_reg.is_read;

    // not-ready and step hold are taken on the falling clock edge
    always_ff @(negedge mclk or negedge nrst) begin
        if (!nrst) begin
            wait_fall_reg <= 1'b1;
            step_fall_reg <= 1'b1;
        end else begin
            wait_fall_reg <= not_ready_n;
            step_fall_reg <= step_hold_n;
        end
    end

    // step hold stalls the core between instructions
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            core_step_stall <= 1'b0;
        else
            core_step_stall <= ~step_fall_reg;
    end

    // reset release is counted so boot waits the settle time
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            rst_cnt_reg <= 3'h0;
        else if (rst_cnt_reg != 3'(cbp_pkg::reset_settle_clocks))
            rst_cnt_reg <= rst_cnt_reg + 3'h1;
    end

    // bus cycle state machine; each memory or io cycle is t1, t2, waits, t3
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= cbp_pkg::cbp_st_reset;
            cur_reg <= '0;
            boot_idx_reg <= 2'h0;
            booted_reg <= 1'b0;
        end else begin
            case (state_reg)
                cbp_pkg::cbp_st_reset: begin
                    if (rst_cnt_reg == 3'(cbp_pkg::reset_settle_clocks))
                        state_reg <= cbp_pkg::cbp_st_boot;
                end
                cbp_pkg::cbp_st_boot: begin
                    cur_reg <= '{valid: 1'b1, is_mem: 1'b1, is_read: 1'b1, is_byte: 1'b0,
                                 addr: boot_addr, seg: '0, wdata: '0};
                    state_reg <= cbp_pkg::cbp_st_t1;
                end
                cbp_pkg::cbp_st_idle: begin
                    if (!bus_claim_n)
                        state_reg <= cbp_pkg::cbp_st_granted;
                    else if (core_req.valid && !core_step_stall) begin
                        cur_reg <= core_req;
                        state_reg <= cbp_pkg::cbp_st_t1;
                    end
                end
                cbp_pkg::cbp_st_t1: state_reg <= cbp_pkg::cbp_st_t2;
                cbp_pkg::cbp_st_t2: begin
                    if (!wait_fall_reg)
                        state_reg <= cbp_pkg::cbp_st_wait;
                    else
                        state_reg <= cbp_pkg::cbp_st_t3;
                end
                cbp_pkg::cbp_st_wait: begin
                    if (wait_fall_reg)
                        state_reg <= cbp_pkg::cbp_st_t3;
                end
                cbp_pkg::cbp_st_t3: begin
                    if (!booted_reg) begin
                        if (boot_idx_reg == 2'h2) begin
                            booted_reg <= 1'b1;
                            state_reg <= cbp_pkg::cbp_st_idle;
                        end else begin
                            boot_idx_reg <= boot_idx_reg + 2'h1;
                            state_reg <= cbp_pkg::cbp_st_boot;
                        end
                    end else begin
                        state_reg <= cbp_pkg::cbp_st_idle;
                    end
                end
                cbp_pkg::cbp_st_granted: begin
                    if (bus_claim_n)
                        state_reg <= cbp_pkg::cbp_st_idle;
                end
                default: state_reg <= cbp_pkg::cbp_st_reset;
            endcase
        end
    end

    // interrupt sampling tick at the start of every third t-state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            phase_cnt_reg <= 2'h0;
        else if (phase_cnt_reg == 2'(cbp_pkg::irq_sample_period - 1))
            phase_cnt_reg <= 2'h0;
        else
            phase_cnt_reg <= phase_cnt_reg + 2'h1;
    end

    cbp_irq_sampler u_irq (
        .mclk(mclk),
        .nrst(nrst),
        .sample_now(phase_cnt_reg == 2'h0),
        .nmi_n(nmi_n),
        .vectored_irq_n(vectored_irq_n),
        .plain_irq_n(plain_irq_n),
        .translation_trap_n(translation_trap_n),
        .taken(irq_taken),
        .irq_kind(core_irq)
    );

    // pin drivers; all registered so outputs settle on the rising edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mux_bus_out <= '0;
            mux_bus_oe <= 1'b0;
            addr_strobe_n <= 1'b1;
            data_strobe_n <= 1'b1;
            mem_cycle_n <= 1'b1;
            read_not_write <= 1'b1;
            byte_select <= 1'b0;
            normal_mode <= 1'b0;
            ctrl_oe <= 1'b1;
            segment_number_out <= '0;
            cpu_phase_code <= cbp_pkg::status_reset;
            bus_grant_n <= 1'b1;
        end else begin
            addr_strobe_n <= 1'b1;
            data_strobe_n <= 1'b1;
            case (state_reg)
                cbp_pkg::cbp_st_granted: begin
                    bus_grant_n <= 1'b0;
                    mux_bus_oe <= 1'b0;
                    ctrl_oe <= 1'b0;
                    mem_cycle_n <= 1'b1;
                end
                cbp_pkg::cbp_st_t1: begin
                    bus_grant_n <= 1'b1;
                    ctrl_oe <= 1'b1;
                    mux_bus_oe <= 1'b1;
                    mux_bus_out <= cur_reg.addr;
                    addr_strobe_n <= 1'b0;
                    mem_cycle_n <= ~cur_reg.is_mem;
                    read_not_write <= cur_reg.is_read;
                    byte_select <= cur_reg.is_byte;
                    segment_number_out <= cur_reg.seg;
                    normal_mode <= booted_reg ? core_normal_mode : 1'b0;
                    if (!cur_reg.is_mem)
                        cpu_phase_code <= cbp_pkg::status_io;
                    else if (booted_reg && !cur_reg.is_read)
                        cpu_phase_code <= cbp_pkg::status_mem_write;
                    else
                        cpu_phase_code <= cbp_pkg::status_mem_read;
                end
                cbp_pkg::cbp_st_t2, cbp_pkg::cbp_st_wait: begin
                    data_strobe_n <= 1'b0;
                    mux_bus_oe <= ~cur_reg.is_read;
                    mux_bus_out <= cur_reg.wdata;
                end
                cbp_pkg::cbp_st_t3: begin
                    mux_bus_oe <= 1'b0;
                    mem_cycle_n <= 1'b1;
                    cpu_phase_code <= irq_taken ? cbp_pkg::status_int_ack : cbp_pkg::status_idle;
                end
                cbp_pkg::cbp_st_reset: begin
                    mux_bus_oe <= 1'b0;
                    mem_cycle_n <= 1'b1;
                    bus_grant_n <= 1'b1;
                    segment_number_out <= '0;
                    cpu_phase_code <= cbp_pkg::status_reset;
                end
                default: begin
                    bus_grant_n <= 1'b1;
                    ctrl_oe <= 1'b1;
                    mem_cycle_n <= 1'b1;
                end
            endcase
        end
    end

    // read data captured at t3; done pulses once per cycle after boot, not for the three boot reads
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_resp <= '0;
            core_booted <= 1'b0;
        end else begin
            core_resp.done <= (state_reg == cbp_pkg::cbp_st_t3) && booted_reg;
            if (state_reg == cbp_pkg::cbp_st_t3 && cur_reg.is_read)
                core_resp.rdata <= mux_bus_in;
            core_booted <= booted_reg;
        end
    end

    // daisy chain: pass the chain on unless this unit claims the resource
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chain_out_n <= 1'b1;
            core_chain_owned <= 1'b0;
        end else begin
            chain_out_n <= chain_in_n | core_chain_claim;
            core_chain_owned <= ~chain_in_n & core_chain_claim;
        end
    end
endmodule // cbp_bus_unit
`default_nettype wire

// *** cbp_bus_unit_props.sv ***
// checker for the cpu bus pin unit: strobe, arbitration and reset relations
`timescale 1ns/10ps
`default_nettype none
module cbp_bus_unit_props #(parameter int unsigned seg_w = 7) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic mux_bus_oe,
    input wire logic addr_strobe_n,
    input wire logic data_strobe_n,
    input wire logic mem_cycle_n,
    input wire logic read_not_write,
    input wire logic ctrl_oe,
    input wire logic [seg_w-1:0] segment_number_out,
    input wire logic [3:0] cpu_phase_code,
    input wire logic bus_claim_n,
    input wire logic bus_grant_n,
    input wire logic chain_out_n,
    input wire logic core_chain_claim,
    input wire logic core_step_stall
);
    // all relations are judged on the rising edge, outside reset
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_grant_floats: assert property (!bus_grant_n |-> !mux_bus_oe && !ctrl_oe)
        else $error("bus driven while granted");
    a_reset_levels: assert property ($rose(nrst) |-> addr_strobe_n && data_strobe_n && mem_cycle_n && bus_grant_n
        && chain_out_n && segment_number_out == '0 && cpu_phase_code == 4'hF && !mux_bus_oe)
        else $error("pins not in reset levels at release");
    a_strobe_pulse: assert property ($fell(addr_strobe_n) |=> addr_strobe_n && !data_strobe_n)
        else $error("address strobe not one cycle before data strobe");
    a_io_no_mem: assert property ($fell(addr_strobe_n) && cpu_phase_code == cbp_pkg::status_io |-> mem_cycle_n)
        else $error("memory cycle flagged on io transfer");
    a_write_drives: assert property (!data_strobe_n && !read_not_write |-> mux_bus_oe)
        else $error("write data not driven");
    a_read_floats: assert property (!data_strobe_n && read_not_write |-> !mux_bus_oe)
        else $error("bus driven during read");
    a_grant_cause: assert property ($fell(bus_grant_n) |-> !$past(bus_claim_n) && !mux_bus_oe)
        else $error("grant without held claim");
    a_grant_return: assert property ($rose(bus_grant_n) |-> $past(bus_claim_n))
        else $error("grant ended while still claimed");
    a_chain_block: assert property (core_chain_claim |-> ##[0:1] chain_out_n)
        else $error("chain passed on while claiming");
    a_step_quiet: assert property ($fell(addr_strobe_n) |-> !$past(core_step_stall))
        else $error("cycle started while stalled");
    c_granted: cover property ($fell(bus_grant_n));
    c_io_cycle: cover property ($fell(addr_strobe_n) && cpu_phase_code == cbp_pkg::status_io);
    c_write: cover property (!data_strobe_n && !read_not_write);
endmodule // cbp_bus_unit_props
bind cbp_bus_unit cbp_bus_unit_props #(.seg_w(seg_w)) i_cbp_bus_unit_props (.*);
`default_nettype wire

// *** cbp_mem_model.sv ***
// memory and io partner: logs strobed cycles, answers reads, inserts wait states
`timescale 1ns/10ps
`default_nettype none
module cbp_mem_model (
    input wire logic mclk,
    input wire logic [15:0] bus_out,
    input wire logic bus_oe,
    input wire logic addr_strobe_n,
    input wire logic data_strobe_n,
    input wire logic [10:0] quals,
    input wire logic [7:0] wait_cycles,
    output logic [15:0] bus_in,
    output logic not_ready_n
);
    logic [15:0] addr_reg = 16'h0000;
    logic [15:0] last_reg = 16'h0000;
    logic [7:0] cnt_reg = 8'h00;
    logic [15:0] addr_q[$];
    logic [10:0] info_q[$];
    logic [15:0] wdata_q[$];
    // a released line never repeats its last value, so a late sample cannot pass by luck
    assign bus_in = bus_oe ? bus_out : (!data_strobe_n && quals[9]) ? addr_reg ^ 16'h5A3C : ~last_reg;
    always @(posedge mclk) last_reg <= bus_in;
    // not-ready answers at once, so the unit already sees it at the falling edge of the address slot
    assign not_ready_n = !((!addr_strobe_n && wait_cycles != 8'h00) || cnt_reg > 8'h01);
    // address and qualifiers logged while the strobe is low; the wait count is armed in the same slot
    always @(negedge mclk) begin
        if (!addr_strobe_n) begin
            addr_reg <= bus_out;
            addr_q.push_back(bus_out);
            info_q.push_back(quals);
            cnt_reg <= wait_cycles;
        end else if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
        end else begin
            cnt_reg <= 8'h00;
        end
        if (!data_strobe_n && !quals[9] && bus_oe) wdata_q.push_back(bus_out);
    end
endmodule // cbp_mem_model
`default_nettype wire

// *** cbp_bus_unit_bench.sv ***
// self-checking bench for the cpu bus pin unit
`timescale 1ns/10ps
`default_nettype none
module cbp_bus_unit_bench;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] mux_bus_in, mux_bus_out;
    logic mux_bus_oe, addr_strobe_n, data_strobe_n, mem_cycle_n, read_not_write, byte_select, normal_mode, ctrl_oe;
    logic [6:0] segment_number_out;
    logic [3:0] cpu_phase_code;
    logic bus_claim_n = 1'b1, bus_grant_n, chain_in_n = 1'b1, chain_out_n, not_ready_n, step_hold_n = 1'b1;
    logic nmi_n = 1'b1, vectored_irq_n = 1'b1, plain_irq_n = 1'b1, translation_trap_n = 1'b1;
    logic core_normal_mode = 1'b0, core_chain_claim = 1'b0, core_booted, core_step_stall, core_chain_owned;
    logic [7:0] waits = 8'h00;
    cbp_pkg::cbp_req_type core_req = '0;
    cbp_pkg::cbp_resp_type core_resp;
    cbp_pkg::cbp_irq_type core_irq;
    int n_errors = 0, n_compared = 0, cycles = 0;
    cbp_bus_unit i_cbp_bus_unit (.*);
    cbp_mem_model i_cbp_mem_model (.mclk(mclk), .bus_out(mux_bus_out), .bus_oe(mux_bus_oe),
        .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n), .wait_cycles(waits), .bus_in(mux_bus_in),
        .quals({mem_cycle_n, read_not_write, byte_select, normal_mode, segment_number_out}), .not_ready_n(not_ready_n));
    always #50 mclk = ~mclk;
    // a hang ends the run as a failure
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // bounded wait for the done pulse, then the request is withdrawn so it is not taken again
    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (core_resp.done !== 1'b1 && n < 60);
        core_req.valid <= 1'b0;
    endtask
    task automatic clear_log();
        i_cbp_mem_model.addr_q.delete();
        i_cbp_mem_model.info_q.delete();
        i_cbp_mem_model.wdata_q.delete();
    endtask
    // reset levels, then the three boot reads in system mode
    task automatic do_reset();
        @(negedge mclk);
        nrst <= 1'b0;
        waits <= 8'h00;
        repeat (5) @(negedge mclk);
        check("reset strobes", {mux_bus_oe, addr_strobe_n, data_strobe_n, mem_cycle_n, bus_grant_n, chain_out_n}, 16'h001F);
        check("reset status", {segment_number_out, cpu_phase_code}, 16'h000F);
        clear_log();
        nrst <= 1'b1;
        for (int n = 0; n < 80 && core_booted !== 1'b1; n++) @(negedge mclk);
        check("booted", core_booted, 1'b1);
        for (int k = 0; k < 3; k++) begin
            check("boot address", i_cbp_mem_model.addr_q[k], 16'h0002 + 16'(2 * k));
            check("boot kind", {i_cbp_mem_model.info_q[k][10:9], i_cbp_mem_model.info_q[k][7]}, 16'h0002);
        end
    endtask
    // one transfer with a chosen number of wait states; the mode follows the byte flag for variety
    task automatic xfer(input logic m, input logic r, input logic b, input logic [15:0] a, input logic [7:0] w);
        int n;
        @(negedge mclk);
        clear_log();
        waits <= w;
        core_normal_mode <= b;
        core_req <= '{1'b1, m, r, b, a, a[6:0], ~a};
        wait_done(n);
        check("latency", 16'(n), 16'(4 + w));
        check("address", i_cbp_mem_model.addr_q[0], a);
        check("qualifiers", i_cbp_mem_model.info_q[0], {~m, r, b, b, a[6:0]});
        if (r) check("read data", core_resp.rdata, a ^ 16'h5A3C);
        else check("write data", i_cbp_mem_model.wdata_q[$], ~a);
    endtask
    // a request made while the bus is handed over is held off until the claim ends
    task automatic t_arbit();
        int n;
        @(negedge mclk);
        bus_claim_n <= 1'b0;
        repeat (4) @(negedge mclk);
        check("grant", bus_grant_n, 1'b0);
        check("released pins", {mux_bus_oe, ctrl_oe}, 16'h0000);
        clear_log();
        core_req <= '{1'b1, 1'b1, 1'b1, 1'b0, 16'h0200, 7'h00, 16'h0000};
        repeat (6) @(negedge mclk);
        check("cycles while granted", 16'(i_cbp_mem_model.addr_q.size()), 16'h0000);
        bus_claim_n <= 1'b1;
        wait_done(n);
        check("grant", bus_grant_n, 1'b1);
        check("cycles after release", 16'(i_cbp_mem_model.addr_q.size()), 16'h0001);
    endtask
    // single-step hold stalls new cycles until it is let go
    task automatic t_step();
        int n;
        @(negedge mclk);
        step_hold_n <= 1'b0;
        repeat (3) @(negedge mclk);
        check("stall", core_step_stall, 1'b1);
        clear_log();
        core_req <= '{1'b1, 1'b1, 1'b0, 1'b0, 16'h0300, 7'h00, 16'h1111};
        repeat (6) @(negedge mclk);
        check("cycles while stalled", 16'(i_cbp_mem_model.addr_q.size()), 16'h0000);
        step_hold_n <= 1'b1;
        wait_done(n);
        check("cycles after step", 16'(i_cbp_mem_model.addr_q.size()), 16'h0001);
    endtask
    // the chain passes the grant on only when this unit is not claiming
    task automatic t_chain();
        @(negedge mclk);
        core_chain_claim <= 1'b1;
        chain_in_n <= 1'b0;
        repeat (3) @(negedge mclk);
        check("chain out", chain_out_n, 1'b1);
        check("chain owned", core_chain_owned, 1'b1);
        core_chain_claim <= 1'b0;
        repeat (3) @(negedge mclk);
        check("chain out", chain_out_n, 1'b0);
        chain_in_n <= 1'b1;
        repeat (3) @(negedge mclk);
        check("chain out", chain_out_n, 1'b1);
    endtask
    // priority and edge behaviour: a held nmi level is not a second request
    task automatic t_irq();
        @(negedge mclk);
        nmi_n <= 1'b0;
        vectored_irq_n <= 1'b0;
        plain_irq_n <= 1'b0;
        repeat (12) @(negedge mclk);
        check("irq pick", core_irq, cbp_pkg::cbp_irq_nmi);
        xfer(1'b1, 1'b1, 1'b0, 16'h0100, 8'h00);
        check("ack status", cpu_phase_code, cbp_pkg::status_int_ack);
        repeat (12) @(negedge mclk);
        check("irq pick", core_irq, cbp_pkg::cbp_irq_vect);
        vectored_irq_n <= 1'b1;
        xfer(1'b1, 1'b1, 1'b0, 16'h0102, 8'h00);
        repeat (12) @(negedge mclk);
        check("irq pick", core_irq, cbp_pkg::cbp_irq_plain);
        plain_irq_n <= 1'b1;
        nmi_n <= 1'b1;
        xfer(1'b1, 1'b1, 1'b0, 16'h0104, 8'h00);
        translation_trap_n <= 1'b0;
        repeat (12) @(negedge mclk);
        check("irq pick", core_irq, cbp_pkg::cbp_irq_trap);
        translation_trap_n <= 1'b1;
        xfer(1'b1, 1'b1, 1'b0, 16'h0106, 8'h00);
        repeat (12) @(negedge mclk);
        check("irq pick", core_irq, cbp_pkg::cbp_irq_none);
    endtask
    initial begin
        do_reset();
        xfer(1'b1, 1'b1, 1'b0, 16'h1234, 8'h00);
        xfer(1'b1, 1'b0, 1'b1, 16'hFFFE, 8'h02);
        xfer(1'b0, 1'b1, 1'b1, 16'h0081, 8'h01);
        xfer(1'b0, 1'b0, 1'b0, 16'h8000, 8'h00);
        t_arbit();
        t_step();
        t_chain();
        t_irq();
        do_reset();
        xfer(1'b1, 1'b0, 1'b0, 16'h7F7F, 8'h01);
        close_out();
    end
endmodule // cbp_bus_unit_bench
`default_nettype wire
